// [secsup_pkg.sv]
// Shared constants and types of the security mode and fault supervisor
package secsup_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int AREA_IDX_W = 10;
  // Register word indices
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_CTRL = 6'h01;
  localparam logic [5:0] OFS_RST_CAUSE = 6'h02;
  localparam logic [5:0] OFS_EXC_CAUSE = 6'h03;
  localparam logic [5:0] OFS_AREA_IDX = 6'h04;
  localparam logic [5:0] OFS_AREA_DATA = 6'h05;
  localparam logic [5:0] OFS_WPROT = 6'h06;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MAP_BIT = 4;
  localparam logic [1:0] REQ_TEST = 2'h1;
  localparam logic [1:0] REQ_FW = 2'h2;
  localparam logic [1:0] REQ_BOOT = 2'h3;
  localparam logic CTRL_MAP_RESET = 1'b0;
  // Manufacturer area layout, byte indices inside the area; card-disable and erase bytes are indices inside the write-once sub-area
  localparam int MFR_AREA_BYTES = 768;
  localparam int RO_BASE = 688;
  localparam int RO_LEN = 32;
  localparam int WP_BASE = 720;
  localparam int WP_LEN = 16;
  localparam int WO_BASE = 736;
  localparam int WO_LEN = 32;
  localparam int CARD_DIS_BYTE = 30;
  localparam int ERASE_BYTE = 31;
  // Reset cause bits
  localparam int RC_ROM = 0;
  localparam int RC_NV = 1;
  localparam int RC_SCAN0 = 2;
  localparam int RC_RDPAR0 = 4;
  localparam int RC_SENSOR = 6;
  localparam int RC_FUSE = 7;
  // Exception cause bits
  localparam int EC_ACCESS = 0;
  localparam int EC_MODE = 1;
  localparam int EC_SENSOR = 2;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  typedef enum logic [3:0] {
    MODE_BOOT = 4'b0001,
    MODE_TEST = 4'b0010,
    MODE_FW = 4'b0100,
    MODE_HALT = 4'b1000
  } mode_e;

  typedef struct packed {
    logic rd;
    logic [7:0] data;
    logic par;
  } ram_port_s;

  typedef struct packed {
    logic delivered;
    logic card_dis_opt;
    logic erase_opt;
    logic [1:0] ram_par_en;
    logic [7:0] cal;
    logic [7:0] check;
  } fuse_s;

  typedef struct packed {
    logic [7:0] data;
    logic [4:0] ecc;
  } nv_word_s;
endpackage : secsup_pkg

// [security_mode_and_fault_supervisor.sv]
// Mode state machine, manufacturer user areas and memory fault supervision
//
// Overview of operation
// - Reset or power-up always enters boot mode
// - Boot mode reachable only through reset
// - Boot leaves only to test or firmware
// - Firmware mode never goes to test
// - Delivered part: no test mode, test ROM off
// - Loader disabled permanently once delivered
// - Manufacturer area is top 768 NV bytes
// - Area access depends on mode and mapping
// - Fuse bytes checked at boot before use
// - 32-byte user area is read only
// - 16-byte area writable until protected
// - 32-byte area bits set once, never cleared; here power-up clears them
// - Card-disable byte blocks start-up after reset
// - Erase byte wipes application flash and NV
// - Faults force reset or raise exception
// - Fault reset records readable reset cause
// - Exception interrupts, vectors, records cause
// - ROM read parity failure forces reset
// - NV reads correct one bit per word
// - Uncorrectable NV error forces reset
// - Both RAMs scanned continuously for parity
// - Optional RAM read parity causes reset
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module security_mode_and_fault_supervisor #(
  parameter int RAM_AW = 8,
  parameter int SENSOR_N = 4,
  parameter logic [SENSOR_N-1:0] SENSOR_RESET = 4'h3,
  parameter logic [8*32-1:0] RO_INIT = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_on,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire secsup_pkg::fuse_s fuse,
  input wire logic rom_rd,
  input wire logic rom_par_fail,
  input wire logic nv_rd,
  input wire secsup_pkg::nv_word_s nv_word,
  output logic nv_valid,
  output logic [7:0] nv_data,
  input wire secsup_pkg::ram_port_s [1:0] ram_rd,
  input wire secsup_pkg::ram_port_s [1:0] scan_rd,
  output logic [1:0][RAM_AW-1:0] scan_addr,
  input wire logic [SENSOR_N-1:0] sensor_fault,
  input wire logic erase_done,
  output secsup_pkg::mode_e mode,
  output logic loader_en,
  output logic test_rom_en,
  output logic card_blocked,
  output logic erase_req,
  output logic fault_reset,
  output logic exc_req
);
  generate
    if (RAM_AW < 1 || RAM_AW > 24 || SENSOR_N < 1 || SENSOR_N > 8) begin : g_bad
      $error("Unsupported RAM_AW or SENSOR_N");
    end
  endgenerate

  secsup_pkg::mode_e mode_reg, mode_next;
  logic booted_reg;
  logic delivered_reg;
  logic [1:0] par_en_reg;
  logic card_opt_reg;
  logic erase_opt_reg;
  localparam int AREA_IDX_W_L = secsup_pkg::AREA_IDX_W;
  logic map_en_reg;
  logic [AREA_IDX_W_L-1:0] area_idx_reg;
  logic [7:0] wp_mem [secsup_pkg::WP_LEN];
  logic [7:0] wo_mem [secsup_pkg::WO_LEN];
  logic wp_lock_reg;
  logic [7:0] rst_cause_reg;
  logic [7:0] exc_cause_reg;
  logic [7:0] rst_evt;
  logic [7:0] exc_evt;
  logic [1:0] scan_fail;
  logic [1:0] rdpar_fail;
  logic nv_uncorr;
  logic [7:0] nv_fixed;
  logic fuse_ok;
  logic card_dis;
  logic por;
  logic area_wr;
  logic area_ok;
  logic [7:0] area_byte;
  logic area_refused;
  logic mode_refused;
  logic [31:0] rdata_next;

  assign por = rst & power_on;

  ////////////////////////////////////////////////////////////////////////////
  // Single-error-correcting, double-error-detecting decode of one NV byte
  function automatic logic [8:0] ecc_decode(input secsup_pkg::nv_word_s w);
    logic [12:1] cw;
    logic [3:0] syn;
    logic overall;
    logic [8:0] res;
    cw = {w.data[7:4], w.ecc[3], w.data[3:1], w.ecc[2], w.data[0], w.ecc[1:0]};
    syn = 4'h0;
    overall = w.ecc[4];
    for (int i = 1; i <= 12; i++) begin
      if (cw[i]) begin
        syn = syn ^ 4'(i);
      end
      overall = overall ^ cw[i];
    end
    res = {1'b0, w.data};
    if (syn != 4'h0 && overall) begin
      if (syn <= 4'hC) begin
        cw[syn] = ~cw[syn];
      end
      res = {1'b0, cw[12:9], cw[7:5], cw[3]};
    end else if (syn != 4'h0) begin
      res = {1'b1, w.data};
    end
    return res;
  endfunction : ecc_decode

  assign {nv_uncorr, nv_fixed} = ecc_decode(nv_word);

  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_valid <= 1'b0;
      nv_data <= 8'h00;
    end else if (ce) begin
      nv_valid <= nv_rd & ~nv_uncorr;
      nv_data <= (nv_rd & ~nv_uncorr) ? nv_fixed : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Background parity scanners and read parity checks, one per working RAM
  generate
    for (genvar r = 0; r < 2; r++) begin : g_ram
      logic [RAM_AW-1:0] addr_reg;
      always_ff @(posedge mclk) begin
        if (rst) begin
          addr_reg <= '0;
        end else if (ce) begin
          addr_reg <= addr_reg + 1'b1;
        end
      end
      assign scan_addr[r] = addr_reg;
      assign scan_fail[r] = scan_rd[r].rd & (scan_rd[r].par != ^scan_rd[r].data);
      assign rdpar_fail[r] = par_en_reg[r] & ram_rd[r].rd & (ram_rd[r].par != ^ram_rd[r].data);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fault classification
  // fuse integrity check
  assign fuse_ok = fuse.check == ~(fuse.cal ^ {3'h0, fuse.delivered, fuse.card_dis_opt,
                                               fuse.erase_opt, fuse.ram_par_en});
  assign card_dis = fuse.card_dis_opt & (wo_mem[secsup_pkg::CARD_DIS_BYTE] != 8'h00);

  always_comb begin
    rst_evt = 8'h00;
    rst_evt[secsup_pkg::RC_ROM] = rom_rd & rom_par_fail;
    rst_evt[secsup_pkg::RC_NV] = nv_rd & nv_uncorr;
    rst_evt[secsup_pkg::RC_SCAN0 +: 2] = scan_fail;
    rst_evt[secsup_pkg::RC_RDPAR0 +: 2] = rdpar_fail;
    // sensor faults split into reset or exception class
    rst_evt[secsup_pkg::RC_SENSOR] = |(sensor_fault & SENSOR_RESET);
    rst_evt[secsup_pkg::RC_FUSE] = (mode_reg == secsup_pkg::MODE_BOOT) & ~booted_reg & ~fuse_ok;
    exc_evt = 8'h00;
    exc_evt[secsup_pkg::EC_ACCESS] = area_refused;
    exc_evt[secsup_pkg::EC_MODE] = mode_refused;
    exc_evt[secsup_pkg::EC_SENSOR] = |(sensor_fault & ~SENSOR_RESET);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  always_comb begin
    mode_next = mode_reg;
    mode_refused = 1'b0;
    unique case (mode_reg)
      secsup_pkg::MODE_BOOT: begin
        if (!booted_reg) begin
          if (fuse_ok && card_dis) begin
            mode_next = secsup_pkg::MODE_HALT;
          end
        end else if (reg_wr && reg_addr == secsup_pkg::OFS_CTRL) begin
          // boot exits only to test or firmware
          unique case (reg_wdata[secsup_pkg::CTRL_MODE_LSB +: 2])
            secsup_pkg::REQ_FW: mode_next = secsup_pkg::MODE_FW;
            secsup_pkg::REQ_TEST: begin
              if (delivered_reg) begin
                mode_refused = 1'b1;
              end else begin
                mode_next = secsup_pkg::MODE_TEST;
              end
            end
            secsup_pkg::REQ_BOOT: mode_refused = 1'b1;
            2'h0: mode_next = mode_reg;
          endcase
        end
      end
      secsup_pkg::MODE_TEST, secsup_pkg::MODE_FW: begin
        // boot requests refused, test requests refused in firmware only, mode kept
        if (reg_wr && reg_addr == secsup_pkg::OFS_CTRL &&
            (reg_wdata[1:0] == secsup_pkg::REQ_BOOT ||
             (reg_wdata[1:0] == secsup_pkg::REQ_TEST && mode_reg == secsup_pkg::MODE_FW))) begin
          mode_refused = 1'b1;
        end
      end
      secsup_pkg::MODE_HALT: mode_next = mode_reg;
      default: mode_next = secsup_pkg::MODE_HALT;
    endcase
    if (rst_evt != 8'h00) begin
      mode_next = secsup_pkg::MODE_HALT;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // boot mode first after any reset
      mode_reg <= secsup_pkg::MODE_BOOT;
      booted_reg <= 1'b0;
    end else if (ce) begin
      mode_reg <= mode_next;
      booted_reg <= 1'b1;
    end
  end

  // Fuse configuration is applied only once it has passed the check
  always_ff @(posedge mclk) begin
    if (rst) begin
      delivered_reg <= 1'b1;
      par_en_reg <= 2'h3;
      card_opt_reg <= 1'b0;
      erase_opt_reg <= 1'b0;
    end else if (ce && !booted_reg && fuse_ok) begin
      delivered_reg <= fuse.delivered;
      par_en_reg <= fuse.ram_par_en;
      card_opt_reg <= fuse.card_dis_opt;
      erase_opt_reg <= fuse.erase_opt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manufacturer area user sub-areas
  // index covers top 768 NV bytes
  // granted in boot or firmware with mapping on
  assign area_ok = map_en_reg & (mode_reg == secsup_pkg::MODE_BOOT || mode_reg == secsup_pkg::MODE_FW);
  assign area_wr = reg_wr & (reg_addr == secsup_pkg::OFS_AREA_DATA);

  always_comb begin
    area_byte = 8'h00;
    area_refused = 1'b0;
    if (area_idx_reg >= 10'(secsup_pkg::WO_BASE)) begin
      area_byte = wo_mem[5'(area_idx_reg - 10'(secsup_pkg::WO_BASE))];
    end else if (area_idx_reg >= 10'(secsup_pkg::WP_BASE)) begin
      area_byte = wp_mem[4'(area_idx_reg - 10'(secsup_pkg::WP_BASE))];
      area_refused = area_wr & wp_lock_reg;
    end else if (area_idx_reg >= 10'(secsup_pkg::RO_BASE)) begin
      area_byte = RO_INIT[8*(5'(area_idx_reg - 10'(secsup_pkg::RO_BASE))) +: 8];
      area_refused = area_wr;
    end else begin
      area_refused = area_wr | (reg_rd & reg_addr == secsup_pkg::OFS_AREA_DATA);
    end
    if (!area_ok || area_idx_reg >= 10'(secsup_pkg::MFR_AREA_BYTES)) begin
      area_byte = 8'h00;
      area_refused = area_wr | (reg_rd & reg_addr == secsup_pkg::OFS_AREA_DATA);
    end
  end

  // Sub-area contents survive a plain reset; only power-up clears them
  always_ff @(posedge mclk) begin
    if (por) begin
      wp_lock_reg <= 1'b0;
      for (int i = 0; i < secsup_pkg::WP_LEN; i++) begin
        wp_mem[i] <= 8'h00;
      end
      for (int i = 0; i < secsup_pkg::WO_LEN; i++) begin
        wo_mem[i] <= 8'h00;
      end
    end else if (ce && !rst) begin
      // protection requested by software, one way
      if (reg_wr && reg_addr == secsup_pkg::OFS_WPROT && reg_wdata[0]) begin
        wp_lock_reg <= 1'b1;
      end
      if (area_wr && area_ok && !area_refused) begin
        if (area_idx_reg >= 10'(secsup_pkg::WO_BASE)) begin
          wo_mem[5'(area_idx_reg - 10'(secsup_pkg::WO_BASE))] <= area_byte | reg_wdata[7:0];
        end else begin
          wp_mem[4'(area_idx_reg - 10'(secsup_pkg::WP_BASE))] <= reg_wdata[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      map_en_reg <= secsup_pkg::CTRL_MAP_RESET;
      area_idx_reg <= '0;
    end else if (ce && reg_wr) begin
      if (reg_addr == secsup_pkg::OFS_CTRL) begin
        map_en_reg <= reg_wdata[secsup_pkg::CTRL_MAP_BIT];
      end
      if (reg_addr == secsup_pkg::OFS_AREA_IDX) begin
        area_idx_reg <= reg_wdata[AREA_IDX_W_L-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause records: new events win over a software clear
  always_ff @(posedge mclk) begin
    if (por) begin
      rst_cause_reg <= secsup_pkg::CAUSE_RESET;
    end else if (ce) begin
      // cause kept across the forced reset
      rst_cause_reg <= (rst ? rst_cause_reg :
        (rst_cause_reg & ~((reg_wr && reg_addr == secsup_pkg::OFS_RST_CAUSE) ? reg_wdata[7:0] : 8'h00)))
        | (rst ? 8'h00 : rst_evt);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      exc_cause_reg <= secsup_pkg::CAUSE_RESET;
      exc_req <= 1'b0;
      fault_reset <= 1'b0;
    end else if (ce) begin
      exc_cause_reg <= (exc_cause_reg &
        ~((reg_wr && reg_addr == secsup_pkg::OFS_EXC_CAUSE) ? reg_wdata[7:0] : 8'h00)) | exc_evt;
      exc_req <= (exc_evt != 8'h00) & (rst_evt == 8'h00);
      fault_reset <= rst_evt != 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs derived from mode and options
  always_ff @(posedge mclk) begin
    if (rst) begin
      loader_en <= 1'b0;
      test_rom_en <= 1'b0;
      card_blocked <= 1'b0;
    end else if (ce) begin
      loader_en <= ~delivered_reg & (mode_next == secsup_pkg::MODE_BOOT);
      test_rom_en <= ~delivered_reg & (mode_next == secsup_pkg::MODE_TEST);
      card_blocked <= card_blocked | (!booted_reg && fuse_ok && card_dis);
    end
  end

  always_ff @(posedge mclk) begin
    if (por) begin
      erase_req <= 1'b0;
    end else if (ce) begin
      // erase held until the memories report done
      if (area_wr && area_ok && erase_opt_reg && reg_wdata[7:0] != 8'h00 &&
          area_idx_reg == 10'(secsup_pkg::WO_BASE + secsup_pkg::ERASE_BYTE)) begin
        erase_req <= 1'b1;
      end else if (erase_done) begin
        erase_req <= 1'b0;
      end
    end
  end

  assign mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr)
      secsup_pkg::OFS_STATUS: rdata_next = {22'h0, erase_req, card_blocked, wp_lock_reg,
                                            delivered_reg, card_opt_reg, erase_opt_reg, mode_reg};
      secsup_pkg::OFS_CTRL: rdata_next = {27'h0, map_en_reg, 4'h0};
      secsup_pkg::OFS_RST_CAUSE: rdata_next = {24'h0, rst_cause_reg};
      secsup_pkg::OFS_EXC_CAUSE: rdata_next = {24'h0, exc_cause_reg};
      secsup_pkg::OFS_AREA_IDX: rdata_next = {22'h0, area_idx_reg};
      secsup_pkg::OFS_AREA_DATA: rdata_next = {24'h0, area_byte};
      secsup_pkg::OFS_WPROT: rdata_next = {31'h0, wp_lock_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end
endmodule : security_mode_and_fault_supervisor

// [security_mode_and_fault_supervisor_chk.sv]
// Port assertions for the security mode and fault supervisor
`timescale 1ns/1ps
module security_mode_and_fault_supervisor_chk #(
  parameter int SENSOR_N = 4,
  parameter logic [SENSOR_N-1:0] SENSOR_RESET = 4'h3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire secsup_pkg::fuse_s fuse,
  input wire logic rom_rd,
  input wire logic rom_par_fail,
  input wire logic nv_rd,
  input wire logic nv_valid,
  input wire secsup_pkg::ram_port_s [1:0] ram_rd,
  input wire secsup_pkg::ram_port_s [1:0] scan_rd,
  input wire logic [SENSOR_N-1:0] sensor_fault,
  input wire secsup_pkg::mode_e mode,
  input wire logic loader_en,
  input wire logic test_rom_en,
  input wire logic card_blocked,
  input wire logic erase_req,
  input wire logic fault_reset,
  input wire logic exc_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic scan_bad;
  logic rdpar_bad;
  logic sens_exc;
  // Odd parity seen on a scanner result or an enabled software read
  assign scan_bad = (scan_rd[0].rd && ^{scan_rd[0].data, scan_rd[0].par})
    || (scan_rd[1].rd && ^{scan_rd[1].data, scan_rd[1].par});
  assign rdpar_bad = (ram_rd[0].rd && fuse.ram_par_en[0] && ^{ram_rd[0].data, ram_rd[0].par})
    || (ram_rd[1].rd && fuse.ram_par_en[1] && ^{ram_rd[1].data, ram_rd[1].par});
  assign sens_exc = (|(sensor_fault & ~SENSOR_RESET)) && !(|(sensor_fault & SENSOR_RESET))
    && !(rom_rd && rom_par_fail) && !scan_bad && !rdpar_bad;

  AST_RST_BOOT: assert property (disable iff (1'h0) $fell(rst) |-> mode == secsup_pkg::MODE_BOOT)
    else $error("mode not boot after reset");
  AST_NO_BOOT_ENTRY: assert property (mode != secsup_pkg::MODE_BOOT |=> mode != secsup_pkg::MODE_BOOT)
    else $error("boot entered without reset");
  AST_FW_NO_TEST: assert property (mode == secsup_pkg::MODE_FW |=> mode != secsup_pkg::MODE_TEST)
    else $error("firmware went to test");
  AST_TEST_LOCKED: assert property ((mode == secsup_pkg::MODE_TEST || test_rom_en) |-> !fuse.delivered)
    else $error("test mode on delivered part");
  AST_LOADER_OFF: assert property (fuse.delivered |-> !loader_en)
    else $error("loader enabled on delivered part");
  AST_ROM_PAR: assert property (rom_rd && rom_par_fail |=> fault_reset && mode == secsup_pkg::MODE_HALT)
    else $error("rom parity fault without reset");
  AST_NV_VALID: assert property (nv_valid |-> $past(nv_rd))
    else $error("nv data without read");
  AST_SCAN_PAR: assert property (scan_bad |=> fault_reset && mode == secsup_pkg::MODE_HALT)
    else $error("scan parity fault without reset");
  AST_RD_PAR: assert property (rdpar_bad |=> fault_reset)
    else $error("read parity fault without reset");
  AST_SENS_EXC: assert property (sens_exc |=> exc_req && !fault_reset)
    else $error("sensor exception not raised");
  AST_CARD_OPT: assert property (card_blocked |-> fuse.card_dis_opt)
    else $error("card blocked without option");
endmodule : security_mode_and_fault_supervisor_chk

// [mem_side_model.sv]
// Memory side model: scanned RAM contents and erase completion
`timescale 1ns/1ps
module mem_side_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0][7:0] scan_addr,
  input wire logic [1:0] corrupt,
  input wire logic erase_req,
  output secsup_pkg::ram_port_s [1:0] scan_rd,
  output logic erase_done
);
  logic [1:0] cnt_reg;
  // contents hold even parity unless corrupted
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      scan_rd[i].rd = 1'h1;
      scan_rd[i].data = scan_addr[i] ^ 8'hA5;
      scan_rd[i].par = (^scan_rd[i].data) ^ corrupt[i];
    end
  end
  // erase completes some cycles after request
  always_ff @(posedge mclk) begin
    if (rst || !erase_req) cnt_reg <= 2'h0;
    else if (cnt_reg != 2'h3) cnt_reg <= cnt_reg + 2'h1;
  end
  assign erase_done = (cnt_reg == 2'h3);
endmodule : mem_side_model

// [security_mode_and_fault_supervisor_tb.sv]
// Self-checking testbench for the security mode and fault supervisor
`timescale 1ns/1ps
module security_mode_and_fault_supervisor_tb;
  localparam int RAM_AW = 8;
  logic mclk, rst, power_on, reg_wr, reg_rd, rom_rd, rom_par_fail, nv_rd, nv_valid, erase_done;
  logic loader_en, test_rom_en, card_blocked, erase_req, fault_reset, exc_req;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] nv_data;
  logic [3:0] sensor_fault;
  logic [1:0] corrupt;
  logic [1:0][RAM_AW-1:0] scan_addr;
  secsup_pkg::fuse_s fuse, fuse_next;
  secsup_pkg::nv_word_s nv_word;
  secsup_pkg::ram_port_s [1:0] ram_rd, scan_rd;
  secsup_pkg::mode_e mode;
  int fail_count = 0;
  int n_checks = 0;

  security_mode_and_fault_supervisor #(.RAM_AW(RAM_AW)) security_mode_and_fault_supervisor_inst (
    .mclk, .rst, .ce(1'h1), .power_on, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fuse,
    .rom_rd, .rom_par_fail, .nv_rd, .nv_word, .nv_valid, .nv_data, .ram_rd, .scan_rd, .scan_addr,
    .sensor_fault, .erase_done, .mode, .loader_en, .test_rom_en, .card_blocked, .erase_req,
    .fault_reset, .exc_req);
  mem_side_model mem_side_model_inst (.mclk, .rst, .scan_addr, .corrupt, .erase_req, .scan_rd, .erase_done);

  always #12.5 mclk = ~mclk;

  function automatic secsup_pkg::fuse_s mkf(input logic d, input logic bad);
    mkf = {d, 1'h1, 1'h1, 2'h1, 8'h3C, 8'h00};
    mkf.check = ~(8'h3C ^ {3'h0, d, 4'hD}) ^ {7'h0, bad};
  endfunction : mkf

  function automatic secsup_pkg::nv_word_s enc(input logic [7:0] d);
    logic [12:1] c;
    c = {d[7:4], 1'h0, d[3:1], 1'h0, d[0], 2'h0};
    for (int k = 0; k < 4; k++) begin
      for (int i = 1; i < 13; i++) begin
        if ((i >> k) & 1) c[1 << k] ^= c[i];
      end
    end
    enc = {d, ^c, c[8], c[4], c[2], c[1]};
  endfunction : enc

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic ck(input logic c, input string m);
    n_checks++;
    if (c !== 1'h1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : ck

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 ck((reg_rdata & m) === e, "register read");
  endtask : rd

  task automatic area(input logic [31:0] idx, input logic [7:0] d, input logic [7:0] e);
    wr(secsup_pkg::OFS_AREA_IDX, idx);
    wr(secsup_pkg::OFS_AREA_DATA, {24'h0, d});
    rd(secsup_pkg::OFS_AREA_DATA, {24'h0, e}, 32'hFF);
  endtask : area

  task automatic do_reset(input logic p);
    @(posedge mclk);
    rst <= 1'h1;
    power_on <= p;
    @(posedge mclk);
    fuse <= fuse_next;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    power_on <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic ck_mode(input secsup_pkg::mode_e e);
    @(posedge mclk);
    #1 ck(mode === e, "mode");
  endtask : ck_mode

  // Caller raises a reset-class fault at the edge before the call
  task automatic hit(input int c);
    @(posedge mclk);
    {rom_rd, rom_par_fail, nv_rd, ram_rd, sensor_fault, corrupt} <= '0;
    #1 ck(fault_reset === 1'h1 && mode === secsup_pkg::MODE_HALT, "fault reset");
    do_reset(1'h0);
    rd(secsup_pkg::OFS_RST_CAUSE, 32'h1 << c, 32'hFF);
    do_reset(1'h1);
  endtask : hit

  //////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    ck(mode === secsup_pkg::MODE_BOOT && loader_en === 1'h1, "boot after reset"); // entry
    ck(scan_addr === {8'h02, 8'h02}, "scan address"); // running
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_BOOT);
    ck_mode(secsup_pkg::MODE_BOOT); // refused
    rd(secsup_pkg::OFS_EXC_CAUSE, 32'h2, 32'h2); // cause
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_TEST);
    ck_mode(secsup_pkg::MODE_TEST); // to test
    ck(test_rom_en === 1'h1, "test rom on"); // before delivery
    do_reset(1'h1);
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_FW);
    ck_mode(secsup_pkg::MODE_FW); // to firmware
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_TEST);
    ck_mode(secsup_pkg::MODE_FW); // refused
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_BOOT);
    ck_mode(secsup_pkg::MODE_FW); // refused
    fuse_next = mkf(1'h1, 1'h0);
    do_reset(1'h1);
    wr(secsup_pkg::OFS_CTRL, secsup_pkg::REQ_TEST);
    ck_mode(secsup_pkg::MODE_BOOT); // refused
    ck(loader_en === 1'h0 && test_rom_en === 1'h0, "loader or test rom"); // disabled
    fuse_next = mkf(1'h0, 1'h0);
    do_reset(1'h1);
  endtask : t_modes

  task automatic t_areas;
    wr(secsup_pkg::OFS_CTRL, 32'h10 | secsup_pkg::REQ_FW);
    area(secsup_pkg::RO_BASE + 1, 8'hFF, 8'h00); // read only
    area(secsup_pkg::WP_BASE + 15, 8'h5A, 8'h5A); // writable
    wr(secsup_pkg::OFS_WPROT, 32'h1);
    area(secsup_pkg::WP_BASE + 15, 8'hA5, 8'h5A); // protected
    wr(secsup_pkg::OFS_CTRL, 32'h0);
    area(secsup_pkg::WP_BASE + 15, 8'h00, 8'h00); // mapping off
    wr(secsup_pkg::OFS_CTRL, 32'h10);
    area(secsup_pkg::WO_BASE, 8'h0F, 8'h0F); // bits set
    area(secsup_pkg::WO_BASE, 8'hF0, 8'hFF); // more bits
    area(secsup_pkg::WO_BASE, 8'h00, 8'hFF); // no clear
    area(secsup_pkg::MFR_AREA_BYTES + 1, 8'h01, 8'h00); // past the area
    wr(secsup_pkg::OFS_EXC_CAUSE, 32'h1);
    area(32'h0, 8'h11, 8'h00); // refused index
    rd(secsup_pkg::OFS_EXC_CAUSE, 32'h1, 32'h1); // cause
    area(secsup_pkg::WO_BASE + secsup_pkg::ERASE_BYTE, 8'h01, 8'h01);
    ck(erase_req === 1'h1, "erase request"); // erase
    repeat (8) @(posedge mclk);
    #1 ck(erase_req === 1'h0, "erase cleared"); // done
    area(secsup_pkg::WO_BASE + secsup_pkg::CARD_DIS_BYTE, 8'h01, 8'h01);
    do_reset(1'h0);
    ck(card_blocked === 1'h1 && mode === secsup_pkg::MODE_HALT, "card blocked"); // blocked
    do_reset(1'h1);
    ck(card_blocked === 1'h0, "card unblocked");
  endtask : t_areas

  task automatic t_faults;
    secsup_pkg::nv_word_s w;
    w = enc(8'h96);
    @(posedge mclk);
    {rom_rd, rom_par_fail} <= 2'h3;
    hit(secsup_pkg::RC_ROM); // rom
    @(posedge mclk);
    nv_word <= {w.data ^ 8'h08, w.ecc};
    nv_rd <= 1'h1;
    @(posedge mclk);
    nv_rd <= 1'h0;
    #1 ck(nv_valid === 1'h1 && nv_data === 8'h96, "nv correction"); // corrected
    @(posedge mclk);
    nv_word <= {w.data ^ 8'h18, w.ecc};
    nv_rd <= 1'h1;
    hit(secsup_pkg::RC_NV); // double error
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      corrupt <= 2'h1 << i;
      hit(secsup_pkg::RC_SCAN0 + i); // scan
    end
    @(posedge mclk);
    ram_rd[0] <= {1'h1, 8'h01, 1'h0};
    hit(secsup_pkg::RC_RDPAR0); // enabled
    @(posedge mclk);
    ram_rd[1] <= {1'h1, 8'h01, 1'h0};
    @(posedge mclk);
    ram_rd <= '0;
    #1 ck(fault_reset === 1'h0, "disabled read parity"); // disabled
    @(posedge mclk);
    sensor_fault <= 4'h4;
    @(posedge mclk);
    sensor_fault <= 4'h0;
    #1 ck(exc_req === 1'h1 && fault_reset === 1'h0, "exception"); // exception
    rd(secsup_pkg::OFS_EXC_CAUSE, 32'h4, 32'h4); // cause
    @(posedge mclk);
    sensor_fault <= 4'h1;
    hit(secsup_pkg::RC_SENSOR); // reset
    fuse_next = mkf(1'h0, 1'h1);
    do_reset(1'h1);
    ck(mode === secsup_pkg::MODE_HALT, "fuse check"); // bad fuse
    fuse_next = mkf(1'h0, 1'h0);
    do_reset(1'h0);
    rd(secsup_pkg::OFS_RST_CAUSE, 32'h80, 32'hFF); // cause
  endtask : t_faults

  initial begin
    mclk = 1'h0;
    {rst, power_on} = 2'h3;
    {reg_wr, reg_rd, rom_rd, rom_par_fail, nv_rd} = '0;
    {reg_addr, reg_wdata, sensor_fault, corrupt, ram_rd, nv_word} = '0;
    fuse_next = mkf(1'h0, 1'h0);
    fuse = fuse_next;
    do_reset(1'h1);
    t_modes();
    t_areas();
    t_faults();
    end_of_test();
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    end_of_test();
  end
endmodule : security_mode_and_fault_supervisor_tb

bind security_mode_and_fault_supervisor security_mode_and_fault_supervisor_chk #(
  .SENSOR_N(SENSOR_N), .SENSOR_RESET(SENSOR_RESET)) chk_inst (
  .mclk, .rst, .fuse, .rom_rd, .rom_par_fail, .nv_rd, .nv_valid, .ram_rd, .scan_rd, .sensor_fault,
  .mode, .loader_en, .test_rom_en, .card_blocked, .erase_req, .fault_reset, .exc_req);
